//--- logic/pio_pin_stage.sv
// Per-pin output driver, pull-high gating and read selection
`timescale 1ns/1ps
module pio_pin_stage #(parameter int W = 8) (
   input  wire logic clk,
   input  wire logic rst,
   pio_port_if.stage port
);
   import pio_pkg::*;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_pin
         // Output pin reads its latch, input pin reads the live level
         assign port.read_val[i] = port.dir[i] ? port.pin_in[i]
                                               : port.out_latch[i]; // RULE10
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               port.pin_oe[i]   <= 1'b0;
               port.pin_out[i]  <= 1'b1;
               port.pin_pull[i] <= 1'b0;
            end else begin
               port.pin_oe[i]   <= ~port.dir[i]; // RULE9
               port.pin_out[i]  <= port.out_latch[i]; // RULE2
               port.pin_pull[i] <= port.pull_sel[i] & port.dir[i]; // RULE5
            end
         end
      end
   endgenerate

   pull_input_only_a: assert property (@(posedge clk) disable iff (rst)
      (port.pin_pull & port.pin_oe) == '0) // RULE5
      else $error("pull-high active on an output pin");

   drive_follows_dir_a: assert property (@(posedge clk) disable iff (rst)
      port.pin_oe == ~$past(port.dir)) // RULE9
      else $error("output enable does not follow direction");

endmodule // pio_pin_stage

//--- logic/pio_pkg.sv
// Constants, register map and decode helpers for the port I/O block
// Operation
// RULE1 - Port read samples live pin levels, unlatched, at the read edge.
// RULE2 - Written port data stays in an output latch until rewritten.
// RULE3 - Every port A and B pin works as input and output at fixed addresses.
// RULE4 - Port A has one pull-high select bit per pin, 1 enables.
// RULE5 - Pull-high acts only while the pin is an input.
// RULE6 - Port B pull-high bits 5..0 used; bits 7..6 read zero.
// RULE7 - While halted, a falling edge on a wake-enabled port A pin wakes.
// RULE8 - Per-pin wake enable register; disabled pins never wake.
// RULE9 - Direction bit 1 makes an input, 0 a push-pull output.
// RULE10 - Reading an output pin returns the output latch, not the pin.
// RULE11 - Data writes update the latch even while the pin is an input.
package pio_pkg;

   localparam int PA_W = 8;
   localparam int PB_W = 6;
   localparam int ADDR_W = 8;

   // Data-memory addresses of the port registers
   localparam logic [7:0] ADDR_PA_DATA = 8'h10;
   localparam logic [7:0] ADDR_PA_DIR  = 8'h11;
   localparam logic [7:0] ADDR_PA_PU   = 8'h12;
   localparam logic [7:0] ADDR_PA_WU   = 8'h13;
   localparam logic [7:0] ADDR_PB_DATA = 8'h14;
   localparam logic [7:0] ADDR_PB_DIR  = 8'h15;
   localparam logic [7:0] ADDR_PB_PU   = 8'h16;
   localparam logic [7:0] ADDR_SHARE_A = 8'h17;
   localparam logic [7:0] ADDR_SHARE_B = 8'h18;
   localparam logic [7:0] ADDR_REMAP   = 8'h19;

   // Power-on values
   localparam logic [7:0] RST_PA_DATA = 8'hff;
   localparam logic [7:0] RST_PA_DIR  = 8'hff;
   localparam logic [7:0] RST_PA_PU   = 8'h00;
   localparam logic [7:0] RST_PA_WU   = 8'h00;
   localparam logic [5:0] RST_PB_DATA = 6'h3f;
   localparam logic [5:0] RST_PB_DIR  = 6'h3f;
   localparam logic [5:0] RST_PB_PU   = 6'h00;
   localparam logic [7:0] RST_SEL     = 8'h00;

   // Implemented bits of the selector registers
   localparam logic [7:0] MASK_SHARE_A = 8'he0;
   localparam logic [7:0] MASK_SHARE_B = 8'h3e;
   localparam logic [7:0] MASK_REMAP   = 8'hfb;

   function automatic logic addr_hit(input logic [7:0] addr,
                                     input logic [7:0] offset,
                                     input logic       strobe);
      return strobe && (addr == offset);
   endfunction

endpackage

//--- logic/pio_port_if.sv
// Carrier between the register core and a port's pin stage
`timescale 1ns/1ps
interface pio_port_if #(parameter int W = 8);
   logic [W-1:0] out_latch;
   logic [W-1:0] dir;
   logic [W-1:0] pull_sel;
   logic [W-1:0] pin_in;
   logic [W-1:0] read_val;
   logic [W-1:0] pin_out;
   logic [W-1:0] pin_oe;
   logic [W-1:0] pin_pull;

   modport core  (output out_latch, dir, pull_sel, pin_in,
                  input  read_val, pin_out, pin_oe, pin_pull);
   modport stage (input  out_latch, dir, pull_sel, pin_in,
                  output read_val, pin_out, pin_oe, pin_pull);
endinterface

//--- logic/pio_top.sv
// Port A and port B I/O block with pull-high and wake-up
`timescale 1ns/1ps
module pio_top (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic [pio_pkg::ADDR_W-1:0]  mem_addr,
   input  wire logic                        mem_wr,
   input  wire logic [7:0]                  mem_wdata,
   input  wire logic                        mem_rd,
   output logic      [7:0]                  mem_rdata,
   input  wire logic                        halted,
   output logic                             wake,
   input  wire logic [pio_pkg::PA_W-1:0]    pa_in,
   output logic      [pio_pkg::PA_W-1:0]    pa_out,
   output logic      [pio_pkg::PA_W-1:0]    pa_oe,
   output logic      [pio_pkg::PA_W-1:0]    pa_pull,
   input  wire logic [pio_pkg::PB_W-1:0]    pb_in,
   output logic      [pio_pkg::PB_W-1:0]    pb_out,
   output logic      [pio_pkg::PB_W-1:0]    pb_oe,
   output logic      [pio_pkg::PB_W-1:0]    pb_pull
);
   import pio_pkg::*;

   // Register storage
   logic [PA_W-1:0] port_a_data;
   logic [PA_W-1:0] port_a_direction;
   logic [PA_W-1:0] port_a_pullup_select;
   logic [PA_W-1:0] port_a_wakeup_enable;
   logic [PB_W-1:0] port_b_data;
   logic [PB_W-1:0] port_b_direction;
   logic [PB_W-1:0] port_b_pullup_select;
   logic [7:0]      pin_share_select_a;
   logic [7:0]      pin_share_select_b;
   logic [7:0]      input_remap_select;

   // Write decode
   wire wr_pa_data = addr_hit(mem_addr, ADDR_PA_DATA, mem_wr);
   wire wr_pa_dir  = addr_hit(mem_addr, ADDR_PA_DIR,  mem_wr);
   wire wr_pa_pu   = addr_hit(mem_addr, ADDR_PA_PU,   mem_wr);
   wire wr_pa_wu   = addr_hit(mem_addr, ADDR_PA_WU,   mem_wr);
   wire wr_pb_data = addr_hit(mem_addr, ADDR_PB_DATA, mem_wr);
   wire wr_pb_dir  = addr_hit(mem_addr, ADDR_PB_DIR,  mem_wr);
   wire wr_pb_pu   = addr_hit(mem_addr, ADDR_PB_PU,   mem_wr);
   wire wr_shr_a   = addr_hit(mem_addr, ADDR_SHARE_A, mem_wr);
   wire wr_shr_b   = addr_hit(mem_addr, ADDR_SHARE_B, mem_wr);
   wire wr_remap   = addr_hit(mem_addr, ADDR_REMAP,   mem_wr);

   // Latch takes new data whatever the direction
   wire [PA_W-1:0] next_port_a_data =
      wr_pa_data ? mem_wdata : port_a_data; // RULE11
   wire [PA_W-1:0] next_port_a_direction =
      wr_pa_dir ? mem_wdata : port_a_direction; // RULE3
   wire [PA_W-1:0] next_port_a_pullup_select =
      wr_pa_pu ? mem_wdata : port_a_pullup_select; // RULE4
   wire [PA_W-1:0] next_port_a_wakeup_enable =
      wr_pa_wu ? mem_wdata : port_a_wakeup_enable; // RULE8
   wire [PB_W-1:0] next_port_b_data =
      wr_pb_data ? mem_wdata[PB_W-1:0] : port_b_data; // RULE11
   wire [PB_W-1:0] next_port_b_direction =
      wr_pb_dir ? mem_wdata[PB_W-1:0] : port_b_direction; // RULE3
   // Bits 7 and 6 have no storage at all
   wire [PB_W-1:0] next_port_b_pullup_select =
      wr_pb_pu ? mem_wdata[PB_W-1:0] : port_b_pullup_select; // RULE6
   wire [7:0] next_pin_share_select_a =
      wr_shr_a ? (mem_wdata & MASK_SHARE_A) : pin_share_select_a;
   wire [7:0] next_pin_share_select_b =
      wr_shr_b ? (mem_wdata & MASK_SHARE_B) : pin_share_select_b;
   wire [7:0] next_input_remap_select =
      wr_remap ? (mem_wdata & MASK_REMAP) : input_remap_select;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         port_a_data          <= RST_PA_DATA;
         port_a_direction     <= RST_PA_DIR;
         port_a_pullup_select <= RST_PA_PU;
         port_a_wakeup_enable <= RST_PA_WU;
         port_b_data          <= RST_PB_DATA;
         port_b_direction     <= RST_PB_DIR;
         port_b_pullup_select <= RST_PB_PU;
      end else begin
         port_a_data          <= next_port_a_data; // RULE2
         port_a_direction     <= next_port_a_direction;
         port_a_pullup_select <= next_port_a_pullup_select;
         port_a_wakeup_enable <= next_port_a_wakeup_enable;
         port_b_data          <= next_port_b_data; // RULE2
         port_b_direction     <= next_port_b_direction;
         port_b_pullup_select <= next_port_b_pullup_select;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_share_select_a <= RST_SEL;
         pin_share_select_b <= RST_SEL;
         input_remap_select <= RST_SEL;
      end else begin
         pin_share_select_a <= next_pin_share_select_a;
         pin_share_select_b <= next_pin_share_select_b;
         input_remap_select <= next_input_remap_select;
      end
   end

   // Pin stages
   pio_port_if #(.W(PA_W)) pa_if ();
   pio_port_if #(.W(PB_W)) pb_if ();

   assign pa_if.out_latch = port_a_data;
   assign pa_if.dir       = port_a_direction;
   assign pa_if.pull_sel  = port_a_pullup_select;
   assign pa_if.pin_in    = pa_in;
   assign pb_if.out_latch = port_b_data;
   assign pb_if.dir       = port_b_direction;
   assign pb_if.pull_sel  = port_b_pullup_select;
   assign pb_if.pin_in    = pb_in;

   pio_pin_stage #(.W(PA_W)) u_pa_stage (
      .clk  (clk),
      .rst  (rst),
      .port (pa_if.stage)
   );

   pio_pin_stage #(.W(PB_W)) u_pb_stage (
      .clk  (clk),
      .rst  (rst),
      .port (pb_if.stage)
   );

   assign pa_out  = pa_if.pin_out;
   assign pa_oe   = pa_if.pin_oe;
   assign pa_pull = pa_if.pin_pull;
   assign pb_out  = pb_if.pin_out;
   assign pb_oe   = pb_if.pin_oe;
   assign pb_pull = pb_if.pin_pull;

   pio_wake u_wake (
      .clk     (clk),
      .rst     (rst),
      .halted  (halted),
      .pin_in  (pa_in),
      .wake_en (port_a_wakeup_enable),
      .wake    (wake)
   );

   // Read selection; pins sampled at the read edge, no input latch
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      case (mem_addr)
         ADDR_PA_DATA: rd_mux = pa_if.read_val; // RULE1
         ADDR_PA_DIR:  rd_mux = port_a_direction;
         ADDR_PA_PU:   rd_mux = port_a_pullup_select;
         ADDR_PA_WU:   rd_mux = port_a_wakeup_enable;
         ADDR_PB_DATA: rd_mux = {2'b00, pb_if.read_val}; // RULE1
         ADDR_PB_DIR:  rd_mux = {2'b00, port_b_direction};
         ADDR_PB_PU:   rd_mux = {2'b00, port_b_pullup_select}; // RULE6
         ADDR_SHARE_A: rd_mux = pin_share_select_a;
         ADDR_SHARE_B: rd_mux = pin_share_select_b;
         ADDR_REMAP:   rd_mux = input_remap_select;
         default:      rd_mux = 8'h00;
      endcase
   end

   // Read data holds until the next read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_rdata <= 8'h00;
      end else if (mem_rd) begin
         mem_rdata <= rd_mux;
      end
   end

   live_pin_read_a: assert property (@(posedge clk) disable iff (rst)
      (mem_rd && mem_addr == ADDR_PA_DATA)
      |=> mem_rdata == ($past(port_a_direction & pa_in)
                       | $past(~port_a_direction & port_a_data))) // RULE1
      else $error("port A read does not match pins and latch");

   latch_holds_a: assert property (@(posedge clk) disable iff (rst)
      !(mem_wr && mem_addr == ADDR_PA_DATA)
      |=> ##1 pa_out == $past(pa_out)) // RULE2
      else $error("port A output changed without a write");

   write_input_pin_a: assert property (@(posedge clk) disable iff (rst)
      (mem_wr && mem_addr == ADDR_PB_DATA)
      |-> ##2 pb_out == $past(mem_wdata[PB_W-1:0], 2)) // RULE11
      else $error("port B write did not reach the output latch");

   pb_pull_bits_a: assert property (@(posedge clk) disable iff (rst)
      (mem_rd && mem_addr == ADDR_PB_PU) |=> mem_rdata[7:6] == 2'b00) // RULE6
      else $error("port B pull-high upper bits not zero");

   pa_pull_sel_a: assert property (@(posedge clk) disable iff (rst)
      (mem_wr && mem_addr == ADDR_PA_PU)
      |-> ##2 pa_pull ==
         ($past(mem_wdata, 2) & $past(port_a_direction))) // RULE4
      else $error("port A pull-high not taken from select bits");

   dir_output_read_a: assert property (@(posedge clk) disable iff (rst)
      (mem_rd && mem_addr == ADDR_PB_DATA && port_b_direction == '0)
      |=> mem_rdata == {2'b00, $past(port_b_data)}) // RULE10
      else $error("output pin read did not return the latch");

   dir_reg_map_a: assert property (@(posedge clk) disable iff (rst)
      (mem_wr && mem_addr == ADDR_PA_DIR)
      |-> ##2 pa_oe == ~$past(mem_wdata, 2)) // RULE3
      else $error("direction write at fixed address not applied");

endmodule // pio_top

//--- logic/pio_wake.sv
// Falling-edge wake-up detector on port A
`timescale 1ns/1ps
module pio_wake (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      halted,
   input  wire logic [pio_pkg::PA_W-1:0]  pin_in,
   input  wire logic [pio_pkg::PA_W-1:0]  wake_en,
   output logic                           wake
);
   import pio_pkg::*;

   logic [PA_W-1:0] prev_level;
   wire  [PA_W-1:0] fall_hit = prev_level & ~pin_in & wake_en; // RULE8
   wire             next_wake = halted & (|fall_hit); // RULE7

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // Starts high, so a pin held low at reset reads as a fall on the first clock
         prev_level <= '1;
         wake       <= 1'b0;
      end else begin
         prev_level <= pin_in;
         wake       <= next_wake;
      end
   end

   wake_on_fall_a: assert property (@(posedge clk) disable iff (rst)
      (halted && |(prev_level & ~pin_in & wake_en)) |=> wake) // RULE7
      else $error("enabled falling edge while halted gave no wake");

   masked_no_wake_a: assert property (@(posedge clk) disable iff (rst)
      wake |-> $past(|(prev_level & ~pin_in & wake_en))) // RULE8
      else $error("wake raised without an enabled falling edge");

   run_no_wake_a: assert property (@(posedge clk) disable iff (rst)
      !halted |=> !wake) // RULE7
      else $error("wake raised while not halted");

endmodule // pio_wake

//--- tb/pio_pin_model.sv
// External switches and pin loading seen by one port of the block
`timescale 1ns/1ps
module pio_pin_model #(parameter int W = 8) (
   input  wire logic         clk,
   input  wire logic [W-1:0] out,
   input  wire logic [W-1:0] oe,
   input  wire logic [W-1:0] pull,
   input  wire logic [W-1:0] sw_en,
   input  wire logic [W-1:0] sw_val,
   output logic      [W-1:0] level
);
   logic [W-1:0] float_pat = '0;

   // Undriven pins wander so a missing pull-high cannot pass by luck
   always @(posedge clk) begin
      float_pat <= ~float_pat;
   end

   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (oe[i]) begin
            level[i] = out[i];
         end else if (sw_en[i]) begin
            level[i] = sw_val[i];
         end else if (pull[i]) begin
            level[i] = 1'b1;
         end else begin
            level[i] = float_pat[i];
         end
      end
   end
endmodule // pio_pin_model

//--- tb/port_io_pullup_wakeup_bench.sv
// Self-checking bench for the port I/O block
`timescale 1ns/1ps
module port_io_pullup_wakeup_bench;
   import pio_pkg::*;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       mem_wr = 1'b0;
   logic       mem_rd = 1'b0;
   logic       halted = 1'b0;
   logic [7:0] mem_addr = 8'h00;
   logic [7:0] mem_wdata = 8'h00;
   logic [7:0] mem_rdata;
   logic       wake;
   logic [7:0] pa_in, pa_out, pa_oe, pa_pull;
   logic [7:0] pa_sw = 8'ha5;
   logic [7:0] pa_en = 8'hff;
   logic [5:0] pb_in, pb_out, pb_oe, pb_pull;
   logic [5:0] pb_sw = 6'h2c;
   logic [5:0] pb_en = 6'h3f;
   logic [7:0] rv, d, dir, pu, wu;
   logic [7:0] map_a [11] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
                             8'h16, 8'h17, 8'h18, 8'h19, 8'h1a};
   logic [7:0] map_r [11] = '{8'ha5, 8'hff, 8'h00, 8'h00, 8'h2c, 8'h3f,
                             8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] map_m [11] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f,
                             8'h3f, 8'he0, 8'h3e, 8'hfb, 8'h00};
   int         errors = 0;
   int         compares = 0;
   int         seed = 92;
   int         wake_cnt = 0;

   always #50 clk = ~clk;

   pio_top i_dut (.clk(clk), .rst(rst), .mem_addr(mem_addr),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
      .mem_rdata(mem_rdata), .halted(halted), .wake(wake),
      .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pull(pa_pull),
      .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pull(pb_pull));
   pio_pin_model #(.W(8)) i_pa (.clk(clk), .out(pa_out), .oe(pa_oe),
      .pull(pa_pull), .sw_en(pa_en), .sw_val(pa_sw), .level(pa_in));
   pio_pin_model #(.W(6)) i_pb (.clk(clk), .out(pb_out), .oe(pb_oe),
      .pull(pb_pull), .sw_en(pb_en), .sw_val(pb_sw), .level(pb_in));

   always @(posedge clk) begin
      if (wake === 1'b1) begin
         wake_cnt <= wake_cnt + 1;
      end
   end

   // Input pins show the live level, output pins the latch
   function automatic logic [7:0] exp_read(input logic [7:0] dr, pin, lat);
      return (dr & pin) | (~dr & lat);
   endfunction

   task automatic check(input string name, input logic [7:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, v);
      @(posedge clk);
      mem_addr <= a;
      mem_wdata <= v;
      mem_wr <= 1'b1;
      @(posedge clk);
      mem_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      mem_addr <= a;
      mem_rd <= 1'b1;
      @(posedge clk);
      mem_rd <= 1'b0;
      @(negedge clk);
      rv = mem_rdata;
   endtask

   task automatic report_and_stop();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      // Whole run is about a thousand cycles
      #(100 * 20000);
      errors++;
      report_and_stop();
   end

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check("pa_out_rst", pa_out, 8'hff);
      check("pa_oe_rst", pa_oe, 8'h00);
      check("pb_oe_rst", {2'b00, pb_oe}, 8'h00);
      for (int k = 0; k < 11; k++) begin
         rd(map_a[k]);
         check("reset_read", rv, map_r[k]);
      end
      // Skip the data registers: their reads follow the pins
      for (int k = 1; k < 11; k++) begin
         if (k != 4) begin
            d = $random(seed);
            wr(map_a[k], d);
            rd(map_a[k]);
            check("reg_readback", rv, d & map_m[k]);
         end
      end
      for (int n = 0; n < 40; n++) begin
         d = $random(seed);
         dir = (n == 0) ? 8'h00 : ((n == 1) ? 8'hff : $random(seed));
         pu = (n < 2) ? 8'hff : $random(seed);
         wr(ADDR_PA_DATA, d);
         wr(ADDR_PB_DATA, d);
         wr(ADDR_PA_DIR, dir);
         wr(ADDR_PB_DIR, dir);
         wr(ADDR_PA_PU, pu);
         wr(ADDR_PB_PU, pu);
         @(posedge clk);
         pa_en <= dir;
         pb_en <= dir[5:0];
         pa_sw <= $random(seed);
         pb_sw <= $random(seed);
         repeat (2) @(posedge clk);
         rd(ADDR_PA_DATA);
         check("pa_read", rv, exp_read(dir, pa_sw, d));
         rd(ADDR_PB_DATA);
         check("pb_read", rv,
            exp_read(dir & 8'h3f, {2'b00, pb_sw}, d & 8'h3f));
         check("pa_out", pa_out, d);
         check("pb_out", {2'b00, pb_out}, d & 8'h3f);
         check("pa_oe", pa_oe, ~dir);
         check("pb_oe", {2'b00, pb_oe}, ~dir & 8'h3f);
         check("pa_pull", pa_pull, pu & dir);
         check("pb_pull", {2'b00, pb_pull}, pu & dir & 8'h3f);
      end
      wr(ADDR_PA_DIR, 8'hff);
      for (int i = 0; i < 16; i++) begin
         wu = (i < 8) ? 8'hff : $random(seed);
         wr(ADDR_PA_WU, wu);
         @(posedge clk);
         pa_en <= 8'hff;
         pa_sw <= 8'hff;
         halted <= (i < 8) ? 1'b1 : 1'($random(seed));
         repeat (3) @(posedge clk);
         wake_cnt <= 0;
         pa_sw[i % 8] <= 1'b0;
         repeat (5) @(posedge clk);
         @(negedge clk);
         check("wake_count", 8'(wake_cnt),
            {7'h00, halted & wu[i % 8]});
         @(posedge clk);
         halted <= 1'b0;
      end
      report_and_stop();
   end
endmodule // port_io_pullup_wakeup_bench
